// File: design/ssf_pkg.sv
/*
 * constants, field positions and carrier types for the serial status
 * flag block. assumes nothing of its surroundings.
 */
`default_nettype none

package ssf_pkg;

    // byte offsets on the register bus
    localparam logic [2:0] SSF_STATUS_OFS = 3'h0;
    localparam logic [2:0] SSF_CTRL_OFS = 3'h4;

    // values after reset; the status value also after standby entry
    localparam logic [7:0] SSF_STATUS_RST = 8'h84;
    localparam logic [7:0] SSF_CTRL_RST = 8'h00;

    // status register layout
    localparam int SSF_NFLAGS = 5;
    localparam int SSF_FLAG_LO = 3;
    localparam int SSF_TX_COMPLETE_FLAG_POS = 2;
    localparam int SSF_MPB_POS = 1;
    localparam int SSF_TX_MULTIPROC_BIT_POS = 0;

    // index of each flag within the flag vector
    localparam int SSF_F_TX_BUFFER_EMPTY_FLAG = 4;
    localparam int SSF_F_RX_BUFFER_FULL_FLAG = 3;
    localparam int SSF_F_OVERRUN_FLAG = 2;
    localparam int SSF_F_FER = 1;
    localparam int SSF_F_PER = 0;

    // control register, msb first
    typedef struct packed {
        logic rx_irq_enable;
        logic mp_format;
        logic parity_enable;
        logic async_mode;
        logic multiproc_rx_filter_enable;
        logic tx_complete_irq_enable;
        logic rx_on;
        logic tx_on;
    } ssf_ctrl_s;

    // transmit datapath events, one-cycle pulses
    typedef struct packed {
        logic load;
        logic char_end;
    } ssf_tx_evt_s;

    // receive datapath end of character, one-cycle pulse with its data
    typedef struct packed {
        logic done;
        logic stop_bit;
        logic parity_bad;
        logic mp_bit;
    } ssf_rx_evt_s;

    typedef enum logic [0:0] {
        SSF_BUS_IDLE = 1'b0,
        SSF_BUS_ACK = 1'b1
    } ssf_bus_e;

endpackage

`default_nettype wire

// File: design/ssf_flag_cell.sv
/*
 * one software-clearable status flag with its read-as-one tracker.
 * assumes strobes come from logic on the same clock.
 */
`default_nettype none

module ssf_flag_cell #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_init,
    input wire logic i_set,
    input wire logic i_rd_one,
    input wire logic i_wr,
    input wire logic i_wr_bit,
    // state
    output logic o_flag,
    output logic o_armed,
    output logic o_clr
);
    logic flag_reg;
    logic armed_reg;

    assign o_flag = flag_reg;
    assign o_armed = armed_reg;
    assign o_clr = i_wr & ~i_wr_bit & armed_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flag_reg <= RST_VAL;
        end else if (i_init) begin
            flag_reg <= RST_VAL;
        end else if (i_set) begin
            flag_reg <= 1'b1;
        end else if (o_clr) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            armed_reg <= 1'b0;
        end else if (i_init) begin
            armed_reg <= 1'b0;
        end else if (i_rd_one) begin
            armed_reg <= 1'b1;
        end else if (i_wr) begin
            armed_reg <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: design/ssf_top.sv
/*
 * status flags of a serial interface behind an avalon-mm slave.
 * assumes the shift-register datapath on the same clock sends event
 * pulses and that i_standby is a same-clock level.
 */
// What this block does
// - status register is eight bits, 0x84 after reset and standby.
// - writing zero clears flags seven to three; writing one does nothing.
// - tx empty flag clears by read as one, then write zero.
// - tx empty flag sets when holding data moves to shift register.
// - tx empty flag sets whenever transmitter is switched off.
// - rx full flag sets when an error-free character reaches holding.
// - rx full flag clears by read as one, then write zero.
// - overrun sets when a character ends while rx full is set.
// - error flags clear by read as one, then write zero.
// - framing error sets on zero stop bit in asynchronous mode.
// - parity error sets on parity mismatch in asynchronous parity formats.
// - tx complete sets when last bit leaves with tx empty set.
// - tx complete sets whenever transmitter is switched off.
// - tx complete is read-only, cleared by tx empty clear.
// - received multiprocessor bit stored only in async multiprocessor mode.
// - transmit multiprocessor bit double-buffered, used in multiprocessor mode.
// - filter passes mp bit one, sets stored bit, clears filter.
// - tx complete interrupt when flag and its enable are set.
`default_nettype none

module ssf_top
    import ssf_pkg::*;
#(
    parameter int ADDR_W = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // power state
    input wire logic i_standby,
    // datapath events
    input wire ssf_tx_evt_s i_tx_evt,
    input wire ssf_rx_evt_s i_rx_evt,
    // datapath controls
    output logic o_tx_on,
    output logic o_rx_on,
    output logic o_rx_accept,
    output logic o_tx_mp_bit,
    // interrupt requests
    output logic o_tx_complete_irq,
    output logic o_rx_full_irq,
    output logic o_rx_error_irq
);
    ssf_bus_e bus_state_reg;
    logic [7:0] rdata_reg;
    ssf_ctrl_s ctrl_reg;
    logic tx_complete_flag_reg;
    logic mpb_reg;
    logic tx_multiproc_bit_hold_reg;
    logic tx_multiproc_bit_shift_reg;
    logic tei_reg;
    logic rxi_reg;
    logic eri_reg;
    logic [SSF_NFLAGS-1:0] flag_set;
    logic [SSF_NFLAGS-1:0] flag;
    logic [SSF_NFLAGS-1:0] armed;
    logic [SSF_NFLAGS-1:0] clr;
    logic [7:0] status;
    logic req;
    logic accept;
    logic sel_stat;
    logic sel_ctrl;
    logic rd_stat;
    logic wr_stat;
    logic wr_ctrl;
    logic mp_on;
    logic rx_seen;
    logic rx_filtered;
    logic rx_acc;
    logic fer_hit;
    logic per_hit;
    logic ovr_hit;
    logic rx_buffer_full_flag_hit;
    logic mp_wake;
    logic tx_complete_flag_set;

    // bus decode, one wait state per access
    assign req = i_read | i_write;
    assign accept = req & (bus_state_reg == SSF_BUS_ACK);
    assign o_waitrequest = req & (bus_state_reg == SSF_BUS_IDLE);
    assign sel_stat = (i_address == SSF_STATUS_OFS[ADDR_W-1:0]);
    assign sel_ctrl = (i_address == SSF_CTRL_OFS[ADDR_W-1:0]);
    assign rd_stat = accept & i_read & sel_stat;
    assign wr_stat = accept & i_write & sel_stat & i_byteenable[0];
    assign wr_ctrl = accept & i_write & sel_ctrl & i_byteenable[0];
    assign o_readdata = {24'h0000_00, rdata_reg};

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus_state_reg <= SSF_BUS_IDLE;
        end else begin
            unique case (bus_state_reg)
                SSF_BUS_IDLE: begin
                    if (req) begin
                        bus_state_reg <= SSF_BUS_ACK;
                    end
                end
                SSF_BUS_ACK: begin
                    bus_state_reg <= SSF_BUS_IDLE;
                end
            endcase
        end
    end

    // read data captured one edge before acceptance; unmapped reads zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= 8'h00;
        end else if (bus_state_reg == SSF_BUS_IDLE && i_read) begin
            if (sel_stat) begin
                rdata_reg <= status;
            end else if (sel_ctrl) begin
                rdata_reg <= ctrl_reg;
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    assign status = {flag, tx_complete_flag_reg, mpb_reg, tx_multiproc_bit_hold_reg};

    // control register, filter enable dropped on wake-up
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= SSF_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= i_writedata[7:0];
        end else if (mp_wake) begin
            ctrl_reg.multiproc_rx_filter_enable <= 1'b0;
        end
    end

    assign o_tx_on = ctrl_reg.tx_on;
    assign o_rx_on = ctrl_reg.rx_on;

    // receive event decode
    assign mp_on = ctrl_reg.async_mode & ctrl_reg.mp_format;
    assign rx_seen = i_rx_evt.done & ctrl_reg.rx_on;
    assign rx_filtered = rx_seen & mp_on &
        ctrl_reg.multiproc_rx_filter_enable & ~i_rx_evt.mp_bit;
    assign mp_wake = rx_seen & mp_on &
        ctrl_reg.multiproc_rx_filter_enable & i_rx_evt.mp_bit;
    assign rx_acc = rx_seen & ~rx_filtered;
    assign fer_hit = rx_acc & ctrl_reg.async_mode & ~i_rx_evt.stop_bit;
    assign per_hit = rx_acc & ctrl_reg.async_mode &
        ctrl_reg.parity_enable & i_rx_evt.parity_bad;
    assign ovr_hit = rx_acc & flag[SSF_F_RX_BUFFER_FULL_FLAG];
    assign rx_buffer_full_flag_hit = rx_acc & ~flag[SSF_F_RX_BUFFER_FULL_FLAG] & ~fer_hit & ~per_hit;
    assign o_rx_accept = rx_buffer_full_flag_hit;

    assign flag_set[SSF_F_TX_BUFFER_EMPTY_FLAG] = i_tx_evt.load | ~ctrl_reg.tx_on;
    assign flag_set[SSF_F_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag_hit;
    assign flag_set[SSF_F_OVERRUN_FLAG] = ovr_hit;
    assign flag_set[SSF_F_FER] = fer_hit;
    assign flag_set[SSF_F_PER] = per_hit;

    genvar gi;
    generate
        for (gi = 0; gi < SSF_NFLAGS; gi++) begin : g_flag
            ssf_flag_cell #(
                .RST_VAL(SSF_STATUS_RST[SSF_FLAG_LO+gi])
            ) u_cell (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_init(i_standby),
                .i_set(flag_set[gi]),
                .i_rd_one(rd_stat & rdata_reg[SSF_FLAG_LO+gi]),
                .i_wr(wr_stat),
                .i_wr_bit(i_writedata[SSF_FLAG_LO+gi]),
                .o_flag(flag[gi]),
                .o_armed(armed[gi]),
                .o_clr(clr[gi])
            );
        end
    endgenerate

    assign tx_complete_flag_set = ~ctrl_reg.tx_on |
        (i_tx_evt.char_end & flag[SSF_F_TX_BUFFER_EMPTY_FLAG]);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_complete_flag_reg <= SSF_STATUS_RST[SSF_TX_COMPLETE_FLAG_POS];
        end else if (i_standby) begin
            tx_complete_flag_reg <= SSF_STATUS_RST[SSF_TX_COMPLETE_FLAG_POS];
        end else if (tx_complete_flag_set) begin
            tx_complete_flag_reg <= 1'b1;
        end else if (clr[SSF_F_TX_BUFFER_EMPTY_FLAG]) begin
            tx_complete_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mpb_reg <= SSF_STATUS_RST[SSF_MPB_POS];
        end else if (i_standby) begin
            mpb_reg <= SSF_STATUS_RST[SSF_MPB_POS];
        end else if (rx_acc & mp_on) begin
            mpb_reg <= i_rx_evt.mp_bit;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_multiproc_bit_hold_reg <= SSF_STATUS_RST[SSF_TX_MULTIPROC_BIT_POS];
        end else if (i_standby) begin
            tx_multiproc_bit_hold_reg <= SSF_STATUS_RST[SSF_TX_MULTIPROC_BIT_POS];
        end else if (wr_stat) begin
            tx_multiproc_bit_hold_reg <= i_writedata[SSF_TX_MULTIPROC_BIT_POS];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_multiproc_bit_shift_reg <= 1'b0;
        end else if (i_tx_evt.load) begin
            tx_multiproc_bit_shift_reg <= tx_multiproc_bit_hold_reg & mp_on;
        end
    end

    assign o_tx_mp_bit = tx_multiproc_bit_shift_reg;

    // interrupt requests
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tei_reg <= 1'b0;
            rxi_reg <= 1'b0;
            eri_reg <= 1'b0;
        end else begin
            tei_reg <= tx_complete_flag_reg & ctrl_reg.tx_complete_irq_enable;
            rxi_reg <= flag[SSF_F_RX_BUFFER_FULL_FLAG] & ctrl_reg.rx_irq_enable;
            eri_reg <= (flag[SSF_F_OVERRUN_FLAG] | flag[SSF_F_FER] |
                flag[SSF_F_PER]) & ctrl_reg.rx_irq_enable;
        end
    end

    assign o_tx_complete_irq = tei_reg;
    assign o_rx_full_irq = rxi_reg;
    assign o_rx_error_irq = eri_reg;

    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_standby_init: assert property (
        i_standby |=> status == SSF_STATUS_RST)
        else $error("status not 0x84 after standby");

    a_tx_buffer_empty_flag_load: assert property (
        i_tx_evt.load && !i_standby |=> flag[SSF_F_TX_BUFFER_EMPTY_FLAG])
        else $error("tx empty not set by load");

    a_tx_buffer_empty_flag_txoff: assert property (
        !ctrl_reg.tx_on && !wr_ctrl |=> flag[SSF_F_TX_BUFFER_EMPTY_FLAG] [*2])
        else $error("tx empty not held while off");

    a_tx_complete_flag_set: assert property (
        i_tx_evt.char_end && flag[SSF_F_TX_BUFFER_EMPTY_FLAG] |=> tx_complete_flag_reg)
        else $error("tx complete not set at end");

    a_tx_complete_flag_off: assert property (
        !ctrl_reg.tx_on |=> tx_complete_flag_reg)
        else $error("tx complete not set while off");

    a_tx_complete_flag_clear: assert property (
        clr[SSF_F_TX_BUFFER_EMPTY_FLAG] && !tx_complete_flag_set && !i_standby |=> !tx_complete_flag_reg)
        else $error("tx complete not cleared");

    a_rx_buffer_full_flag_set: assert property (
        rx_acc && !flag[SSF_F_RX_BUFFER_FULL_FLAG] && i_rx_evt.stop_bit &&
        !i_rx_evt.parity_bad && !i_standby |=> flag[SSF_F_RX_BUFFER_FULL_FLAG])
        else $error("rx full not set");

    a_overrun_flag_set: assert property (
        rx_seen && !rx_filtered && flag[SSF_F_RX_BUFFER_FULL_FLAG] && !i_standby
        |=> flag[SSF_F_OVERRUN_FLAG] && flag[SSF_F_RX_BUFFER_FULL_FLAG])
        else $error("overrun not flagged");

    a_fer_set: assert property (
        rx_acc && ctrl_reg.async_mode && !i_rx_evt.stop_bit &&
        !i_standby |=> flag[SSF_F_FER] && !$rose(flag[SSF_F_RX_BUFFER_FULL_FLAG]))
        else $error("framing error not flagged");

    a_per_set: assert property (
        rx_acc && ctrl_reg.async_mode && ctrl_reg.parity_enable &&
        i_rx_evt.parity_bad && !i_standby |=> flag[SSF_F_PER])
        else $error("parity error not flagged");

    a_blind_write: assert property (
        wr_stat && !armed[SSF_F_RX_BUFFER_FULL_FLAG] && !i_standby
        |=> !$fell(flag[SSF_F_RX_BUFFER_FULL_FLAG]))
        else $error("flag cleared without prior read");

    a_filter_wake: assert property (
        mp_wake && !wr_ctrl && !i_standby
        |=> mpb_reg && !ctrl_reg.multiproc_rx_filter_enable)
        else $error("filter wake-up mishandled");

    a_tei_out: assert property (
        tx_complete_flag_reg && ctrl_reg.tx_complete_irq_enable |=> o_tx_complete_irq)
        else $error("tx complete irq missing");

    c_tx_buffer_empty_flag_clear: cover property (
        rd_stat && rdata_reg[SSF_FLAG_LO+SSF_F_TX_BUFFER_EMPTY_FLAG] ##[1:20]
        clr[SSF_F_TX_BUFFER_EMPTY_FLAG]);
    c_overrun: cover property (ovr_hit);
    c_mp_wake: cover property (mp_wake);
    c_filtered: cover property (rx_filtered);

endmodule

`default_nettype wire

// File: verif/tb_serial_status_flags.sv
/*
 * self-checking bench for the serial status flag block: avalon-mm
 * register access, datapath event pulses, standby and random chars.
 * assumes ssf_pkg and the design files are compiled first.
 */
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_serial_status_flags import ssf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk;
    logic i_rstn;
    logic [2:0] i_address;
    logic i_read;
    logic i_write;
    logic [31:0] i_writedata;
    logic [3:0] i_byteenable;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic i_standby;
    ssf_tx_evt_s i_tx_evt;
    ssf_rx_evt_s i_rx_evt;
    logic o_tx_on;
    logic o_rx_on;
    logic o_rx_accept;
    logic o_tx_mp_bit;
    logic o_tx_complete_irq;
    logic o_rx_full_irq;
    logic o_rx_error_irq;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic s;
    logic p;

    ssf_top #(.ADDR_W(3)) dut_u (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_standby(i_standby),
        .i_tx_evt(i_tx_evt), .i_rx_evt(i_rx_evt), .o_tx_on(o_tx_on),
        .o_rx_on(o_rx_on), .o_rx_accept(o_rx_accept),
        .o_tx_mp_bit(o_tx_mp_bit), .o_tx_complete_irq(o_tx_complete_irq),
        .o_rx_full_irq(o_rx_full_irq), .o_rx_error_irq(o_rx_error_irq)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic stop_test();
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            stop_test();
        end
    end

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        i_address <= a;
        i_writedata <= {24'h00_0000, d};
        i_write <= w;
        i_read <= !w;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            stop_test();
        end
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [2:0] a, input logic [7:0] e,
                      input string nm);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(nm, {24'h00_0000, e}, q)
    endtask

    task automatic rx(input logic st, pb, mp, acc, input string nm);
        i_rx_evt <= {1'b1, st, pb, mp};
        @(posedge i_clk);
        `CHK(nm, acc, o_rx_accept)
        i_rx_evt <= '0;
        @(posedge i_clk);
    endtask

    task automatic tx(input logic ld, ce);
        i_tx_evt <= {ld, ce};
        @(posedge i_clk);
        i_tx_evt <= '0;
        @(posedge i_clk);
    endtask

    function automatic logic [7:0] rx_exp(input logic st, pb, ovr);
        return 8'h84 | {1'b0, st & ~pb, ovr, ~st, pb, 3'b000};
    endfunction

    initial begin
        i_rstn = 1'b0;
        i_address = 3'h0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0000_0000;
        i_byteenable = 4'hf;
        i_standby = 1'b0;
        i_tx_evt = '0;
        i_rx_evt = '0;
        void'($urandom(99962));
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        rc(SSF_STATUS_OFS, 8'h84, "status_rst");
        rc(SSF_CTRL_OFS, 8'h00, "ctrl_rst");
        rc(3'h2, 8'h00, "unmapped");
        wr(SSF_CTRL_OFS, 8'h01);
        `CHK("tx_on_pin", 1'b1, o_tx_on)
        wr(SSF_STATUS_OFS, 8'hf8);
        wr(SSF_STATUS_OFS, 8'h00);
        rc(SSF_STATUS_OFS, 8'h84, "no_read_clr");
        wr(SSF_STATUS_OFS, 8'h00);
        rc(SSF_STATUS_OFS, 8'h00, "tx_buffer_empty_flag_clr");
        i_standby <= 1'b1;
        @(posedge i_clk);
        i_standby <= 1'b0;
        @(posedge i_clk);
        rc(SSF_STATUS_OFS, 8'h84, "standby");
        wr(SSF_STATUS_OFS, 8'h00);
        wr(SSF_STATUS_OFS, 8'hf9);
        rc(SSF_STATUS_OFS, 8'h01, "write_ones");
        wr(SSF_CTRL_OFS, 8'h51);
        tx(1'b1, 1'b0);
        `CHK("tx_mp", 1'b1, o_tx_mp_bit)
        rc(SSF_STATUS_OFS, 8'h81, "load_sets");
        wr(SSF_STATUS_OFS, 8'h00);
        tx(1'b1, 1'b0);
        `CHK("tx_mp0", 1'b0, o_tx_mp_bit)
        tx(1'b0, 1'b1);
        rc(SSF_STATUS_OFS, 8'h84, "tx_complete_flag_set");
        `CHK("tei_off", 1'b0, o_tx_complete_irq)
        wr(SSF_CTRL_OFS, 8'h55);
        @(posedge i_clk);
        `CHK("tei_on", 1'b1, o_tx_complete_irq)
        wr(SSF_STATUS_OFS, 8'h00);
        rc(SSF_STATUS_OFS, 8'h00, "tx_complete_flag_clr");
        `CHK("tei_clr", 1'b0, o_tx_complete_irq)
        tx(1'b0, 1'b1);
        rc(SSF_STATUS_OFS, 8'h00, "tx_complete_flag_busy");
        wr(SSF_CTRL_OFS, 8'h51);
        tx(1'b1, 1'b0);
        wr(SSF_CTRL_OFS, 8'h55);
        @(posedge i_clk);
        `CHK("tei_quiet", 1'b0, o_tx_complete_irq)
        wr(SSF_CTRL_OFS, 8'h00);
        `CHK("tx_off_pin", 1'b0, o_tx_on)
        rc(SSF_STATUS_OFS, 8'h84, "tx_off");
        wr(SSF_CTRL_OFS, 8'hb2);
        `CHK("rx_on_pin", 1'b1, o_rx_on)
        for (int i = 0; i < 16; i++) begin
            s = (i == 0) ? 1'b0 : (i == 1) ? 1'b1 : ($urandom % 4 != 0);
            p = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : ($urandom % 4 == 0);
            rx(s, p, 1'($urandom), s & ~p, "rx_acc");
            rc(SSF_STATUS_OFS, rx_exp(s, p, 1'b0), "rx_flags");
            `CHK("rxi", s & ~p, o_rx_full_irq)
            `CHK("eri", !s | p, o_rx_error_irq)
            if (s & ~p) begin
                rx(1'b1, 1'b0, 1'b0, 1'b0, "ovr_acc");
                rc(SSF_STATUS_OFS, rx_exp(s, p, 1'b1), "ovr");
            end
            wr(SSF_STATUS_OFS, 8'h00);
            rc(SSF_STATUS_OFS, 8'h84, "rx_clr");
        end
        wr(SSF_CTRL_OFS, 8'h5a);
        rx(1'b1, 1'b0, 1'b0, 1'b0, "filt_drop");
        rc(SSF_STATUS_OFS, 8'h84, "filt_quiet");
        rx(1'b1, 1'b0, 1'b1, 1'b1, "filt_pass");
        rc(SSF_STATUS_OFS, 8'hc6, "mpb_set");
        rc(SSF_CTRL_OFS, 8'h52, "filt_off");
        wr(SSF_STATUS_OFS, 8'h00);
        wr(SSF_CTRL_OFS, 8'h50);
        `CHK("rx_off_pin", 1'b0, o_rx_on)
        rx(1'b1, 1'b0, 1'b0, 1'b0, "rx_off");
        rc(SSF_STATUS_OFS, 8'h86, "mpb_keep");
        i_byteenable <= 4'he;
        wr(SSF_CTRL_OFS, 8'h01);
        i_byteenable <= 4'hf;
        rc(SSF_CTRL_OFS, 8'h50, "be_lane0");
        stop_test();
    end
endmodule

`undef CHK

`default_nettype wire
